/* File: dlio_pkg.sv */
// Package for the 32-line digital I/O port: register map, widths and reset values
package dlio_pkg;
   localparam int unsigned LINES_PER_CONN = 16;
   localparam int unsigned NUM_CONN = 2;
   localparam int unsigned NUM_LINES = LINES_PER_CONN * NUM_CONN;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   localparam logic [7:0] OFF_DIR = 8'h00;
   localparam logic [7:0] OFF_POL = 8'h04;
   localparam logic [7:0] OFF_OUT = 8'h08;
   localparam logic [7:0] OFF_IN = 8'h0c;
   localparam logic [7:0] OFF_IEN = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_MASK = 8'h18;
   localparam logic [7:0] OFF_PWR = 8'h1c;

   localparam logic [31:0] RST_DIR = 32'h0000_0000;
   localparam logic [31:0] RST_POL = 32'h0000_0000;
   localparam logic [31:0] RST_OUT = 32'h0000_0000;
   localparam logic [31:0] RST_IEN = 32'h0000_0000;
   localparam logic [31:0] RST_MASK = 32'h0000_0000;
   localparam logic [31:0] RST_STAT = 32'h0000_0000;
   localparam logic [31:0] RST_SNAP = 32'hffff_ffff;
   localparam logic RST_PWR_KEEP = 1'b0;
   localparam int unsigned PWR_KEEP_BIT = 0;
endpackage

/* File: dlio_sync.sv */
// Two-flop synchroniser bank for the line pins
`timescale 1ns/1ps
module dlio_sync #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // dlio_sync

/* File: dlio_port.sv */
// Top of the 32-line digital I/O port with register port and change interrupt
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Sixteen lines per connector, each own direction
// - Input polarity normal or inverted per line
// - Output lines drive software-programmed level
// - Enabled line change either way raises interrupt if its mask bit is set
// - Reset makes all lines undriven inputs
// - Supply keep-on setting, off in sleep default
module dlio_port (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [31:0] i_digital_line,
   output logic [31:0] o_digital_line,
   output logic [31:0] o_digital_line_oe,
   output logic o_supply_keep_on,
   output logic o_irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   logic [31:0] pin_sync;

   dlio_sync #(.WIDTH(dlio_pkg::NUM_LINES)) u_sync (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_async(i_digital_line),
      .o_sync(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] dir_q, dir_d;
   logic [31:0] pol_q, pol_d;
   logic [31:0] out_q, out_d;
   logic [31:0] ien_q, ien_d;
   logic [31:0] mask_q, mask_d;
   logic [31:0] stat_q, stat_d;
   logic [31:0] state_q, state_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] pin_q, pin_d;
   logic [31:0] oe_q, oe_d;
   logic keep_q, keep_d;
   logic irq_q, irq_d;
   logic [31:0] line_state;
   logic [31:0] change;

   // Address match shared by every write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Reported state: input sees pin through polarity, output reports driven level
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_line
         assign line_state[g] = dir_q[g] ? out_q[g] : (pin_sync[g] ^ pol_q[g]);
      end
   endgenerate

   // Flags follow the reported state, so a fight on an output pin raises none
   assign change = line_state ^ state_q;

   always_comb begin
      dir_d = dir_q;
      pol_d = pol_q;
      out_d = out_q;
      ien_d = ien_q;
      mask_d = mask_q;
      keep_d = keep_q;
      stat_d = stat_q;
      rdata_d = 32'h0000_0000;
      state_d = line_state;
      if (i_wr) begin
         if (hit(i_addr, dlio_pkg::OFF_DIR)) dir_d = i_wdata;
         if (hit(i_addr, dlio_pkg::OFF_POL)) pol_d = i_wdata;
         if (hit(i_addr, dlio_pkg::OFF_OUT)) out_d = i_wdata;
         if (hit(i_addr, dlio_pkg::OFF_IEN)) ien_d = i_wdata;
         if (hit(i_addr, dlio_pkg::OFF_MASK)) mask_d = i_wdata;
         if (hit(i_addr, dlio_pkg::OFF_PWR)) keep_d = i_wdata[dlio_pkg::PWR_KEEP_BIT];
         if (hit(i_addr, dlio_pkg::OFF_STAT)) stat_d = stat_q & ~i_wdata;
      end
      // A change in the clearing cycle still sets its flag
      stat_d = stat_d | (change & ien_q);
      // Read data is zero unless strobed, so several ports may be OR-ed together
      if (i_rd) begin
         unique case (i_addr)
            dlio_pkg::OFF_DIR: rdata_d = dir_q;
            dlio_pkg::OFF_POL: rdata_d = pol_q;
            dlio_pkg::OFF_OUT: rdata_d = out_q;
            dlio_pkg::OFF_IN: rdata_d = line_state;
            dlio_pkg::OFF_IEN: rdata_d = ien_q;
            dlio_pkg::OFF_STAT: rdata_d = stat_q;
            dlio_pkg::OFF_MASK: rdata_d = mask_q;
            dlio_pkg::OFF_PWR: rdata_d = {31'h0000_0000, keep_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // Pins load from the next values, so a write reaches them with the register
      pin_d = out_d;
      oe_d = dir_d;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dir_q <= dlio_pkg::RST_DIR;
         pol_q <= dlio_pkg::RST_POL;
         out_q <= dlio_pkg::RST_OUT;
         ien_q <= dlio_pkg::RST_IEN;
         mask_q <= dlio_pkg::RST_MASK;
         stat_q <= dlio_pkg::RST_STAT;
         keep_q <= dlio_pkg::RST_PWR_KEEP;
         // Pins idle high through pull-ups, so the reset snapshot matches
         state_q <= dlio_pkg::RST_SNAP;
         rdata_q <= 32'h0000_0000;
         pin_q <= 32'h0000_0000;
         oe_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         dir_q <= dir_d;
         pol_q <= pol_d;
         out_q <= out_d;
         ien_q <= ien_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         keep_q <= keep_d;
         state_q <= state_d;
         rdata_q <= rdata_d;
         pin_q <= pin_d;
         oe_q <= oe_d;
         irq_q <= irq_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_digital_line = pin_q;
   assign o_digital_line_oe = oe_q;
   assign o_supply_keep_on = keep_q;
   assign o_irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_oe_follows_dir: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_digital_line_oe == dir_q) else $error("Output enable differs from direction");

   a_out_level: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_digital_line == out_q) else $error("Driven level differs from programmed level");

   a_in_polarity: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_IN && dir_q[0] == 1'b0)
      |=> o_rdata[0] == ($past(pin_sync[0]) ^ $past(pol_q[0])))
      else $error("Input line 0 polarity wrong");

   a_change_sets: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (ien_q[0] && change[0]) |=> stat_q[0]) else $error("Change did not set flag");

   a_flag_holds: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (stat_q[0] && !(i_wr && i_addr == dlio_pkg::OFF_STAT && i_wdata[0])) |=> stat_q[0])
      else $error("Flag dropped without clear");

   a_irq_level: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_irq == |(stat_q & mask_q)) else $error("Interrupt level mismatch");

   a_reset_inputs: assert property (@(posedge i_clock)
      $rose(i_rst_b) |-> o_digital_line_oe == 32'h0000_0000) else $error("Line driven after reset");

   a_keep_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_PWR) |=> o_supply_keep_on == $past(i_wdata[0]))
      else $error("Supply setting not written");

   ////////////////////////////////////////////////////////////////////////////////
   // Writes land at the edge that takes them; without a write the settings hold
   a_dir_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_DIR) |=> dir_q == $past(i_wdata))
      else $error("Direction write lost");

   a_oe_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_DIR) |=> o_digital_line_oe == $past(i_wdata))
      else $error("Output enable did not follow direction write");

   a_oe_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !(i_wr && i_addr == dlio_pkg::OFF_DIR) |=> $stable(o_digital_line_oe))
      else $error("Output enable moved without a write");

   a_pol_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_POL) |=> pol_q == $past(i_wdata))
      else $error("Polarity write lost");

   a_out_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_OUT) |=> o_digital_line == $past(i_wdata))
      else $error("Driven level did not follow output write");

   a_out_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !(i_wr && i_addr == dlio_pkg::OFF_OUT) |=> $stable(o_digital_line))
      else $error("Driven level moved without a write");

   a_ien_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_IEN) |=> ien_q == $past(i_wdata))
      else $error("Interrupt enable write lost");

   a_mask_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_MASK) |=> mask_q == $past(i_wdata))
      else $error("Mask write lost");

   a_keep_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !(i_wr && i_addr == dlio_pkg::OFF_PWR) |=> $stable(o_supply_keep_on))
      else $error("Supply setting moved without a write");

   a_in_read_only: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && i_addr == dlio_pkg::OFF_IN) |=> $stable(dir_q) && $stable(pol_q) && $stable(out_q)
         && $stable(ien_q) && $stable(mask_q) && $stable(o_supply_keep_on))
      else $error("Write to the state register changed a setting");

   ////////////////////////////////////////////////////////////////////////////////
   // Read data stands only in the cycle after the strobe
   a_rd_dir: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_DIR) |=> o_rdata == $past(dir_q))
      else $error("Direction read wrong");

   a_rd_pol: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_POL) |=> o_rdata == $past(pol_q))
      else $error("Polarity read wrong");

   a_rd_out: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_OUT) |=> o_rdata == $past(out_q))
      else $error("Output level read wrong");

   a_rd_ien: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_IEN) |=> o_rdata == $past(ien_q))
      else $error("Interrupt enable read wrong");

   a_rd_stat: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_STAT) |=> o_rdata == $past(stat_q))
      else $error("Flag read wrong");

   a_rd_mask: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_MASK) |=> o_rdata == $past(mask_q))
      else $error("Mask read wrong");

   a_rd_pwr: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr == dlio_pkg::OFF_PWR) |=> o_rdata == {31'h0000_0000, $past(keep_q)})
      else $error("Supply setting read wrong");

   a_rd_unmapped: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_rd && i_addr > dlio_pkg::OFF_PWR) |=> o_rdata == 32'h0000_0000)
      else $error("Unmapped read not zero");

   a_rd_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_rd |=> o_rdata == 32'h0000_0000)
      else $error("Read data without a strobe");

   ////////////////////////////////////////////////////////////////////////////////
   // State at the first edge after reset is released
   a_reset_dir: assert property (@(posedge i_clock)
      $rose(i_rst_b) |-> dir_q == dlio_pkg::RST_DIR) else $error("Direction not cleared by reset");

   a_reset_keep: assert property (@(posedge i_clock)
      $rose(i_rst_b) |-> !o_supply_keep_on) else $error("Supply kept on after reset");

   a_reset_irq: assert property (@(posedge i_clock)
      $rose(i_rst_b) |-> !o_irq) else $error("Interrupt raised after reset");

   ////////////////////////////////////////////////////////////////////////////////
   // Per-line state reporting and change flags
   genvar c;
   generate
      for (c = 0; c < 32; c++) begin : g_line_chk
         a_line_in: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (i_rd && i_addr == dlio_pkg::OFF_IN && !dir_q[c])
            |=> o_rdata[c] == ($past(pin_sync[c]) ^ $past(pol_q[c])))
            else $error("Input line state wrong");

         a_line_out: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (i_rd && i_addr == dlio_pkg::OFF_IN && dir_q[c]) |=> o_rdata[c] == $past(out_q[c]))
            else $error("Output line state wrong");

         a_line_set: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (ien_q[c] && change[c]) |=> stat_q[c]) else $error("Enabled change did not set flag");

         a_line_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (!stat_q[c] && !(ien_q[c] && change[c])) |=> !stat_q[c])
            else $error("Flag set without an enabled change");

         a_line_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (stat_q[c] && !(i_wr && i_addr == dlio_pkg::OFF_STAT && i_wdata[c])) |=> stat_q[c])
            else $error("Line flag dropped without clear");

         a_line_clear: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (stat_q[c] && i_wr && i_addr == dlio_pkg::OFF_STAT && i_wdata[c] && !(ien_q[c] && change[c]))
            |=> !stat_q[c])
            else $error("Line flag not cleared");

         a_line_wakes: assert property (@(posedge i_clock) disable iff (!i_rst_b)
            (stat_q[c] && mask_q[c]) |-> o_irq) else $error("Unmasked flag without interrupt");
      end
   endgenerate
endmodule // dlio_port

/* File: dlio_ext_model.sv */
// External equipment on the digital lines: pull-ups plus an optional driver
`timescale 1ns/1ps
module dlio_ext_model (
   input wire logic [31:0] i_drv_val,
   input wire logic [31:0] i_drv_en,
   input wire logic [31:0] i_dut_out,
   input wire logic [31:0] i_dut_oe,
   output logic [31:0] o_pin
);
   // A line nobody drives floats to the pull-up level
   always_comb begin
      o_pin = (i_dut_oe & i_dut_out) | (~i_dut_oe & ((i_drv_en & i_drv_val) | ~i_drv_en));
   end
endmodule // dlio_ext_model

/* File: digital_io_port_32_line_test.sv */
// Self-checking bench for the 32-line digital I/O port
`timescale 1ns/1ps
module digital_io_port_32_line_test;
   logic i_clock = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, keep, irq;
   logic [7:0] i_addr = '0;
   logic [31:0] i_wdata = '0, o_rdata, pin, dout, doe, ev = '0, ee = '0;
   logic [31:0] dir = '0, pol = '0, out = '0, ien = '0, stat = '0, mask = '0, st = '1;
   int mismatches = 0, tests_run = 0, cyc = 0;
   dlio_port dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_digital_line(pin), .o_digital_line(dout),
      .o_digital_line_oe(doe), .o_supply_keep_on(keep), .o_irq(irq));
   dlio_ext_model ext (.i_drv_val(ev), .i_drv_en(ee), .i_dut_out(dout), .i_dut_oe(doe), .o_pin(pin));
   initial forever #2 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Model of line state and sticky flags; waits out sync and flag latency
   task automatic upd();
      logic [31:0] n;
      n = (dir & out) | (~dir & (((ee & ev) | ~ee) ^ pol));
      stat = stat | (ien & (st ^ n));
      st = n;
      repeat (5) @(posedge i_clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      case (a)
         8'h00: dir = d;
         8'h04: pol = d;
         8'h08: out = d;
         8'h10: ien = d;
         8'h14: stat = stat & ~d;
         8'h18: mask = d;
         default: ;
      endcase
      upd();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk("rdata", e, o_rdata);
      @(posedge i_clock);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      r = $urandom(48791);
      repeat (2) @(posedge i_clock);
      i_rst_b <= 1'b1;
      @(posedge i_clock);
      chk("oe", '0, doe);
      chk("keep", '0, keep);
      for (int a = 0; a < 32; a += 4) rd(a[7:0], a == 12 ? 32'hffff_ffff : 32'h0000_0000);
      wr(8'h10, '1);
      wr(8'h04, $urandom());
      ee <= '1;
      ev <= $urandom();
      @(posedge i_clock);
      upd();
      rd(8'h0c, st);
      rd(8'h14, stat);
      chk("irq", '0, irq);
      wr(8'h18, '1);
      chk("irq", |stat, irq);
      wr(8'h14, '1);
      chk("irq", |stat, irq);
      wr(8'h10, $urandom());
      ee <= $urandom();
      wr(8'h00, $urandom());
      wr(8'h08, $urandom());
      chk("oe", dir, doe);
      chk("out", out, dout);
      chk("pin", out & dir, pin & dir);
      rd(8'h0c, st);
      rd(8'h14, stat);
      chk("irq", |stat, irq);
      wr(8'h18, $urandom());
      chk("irq", |(stat & mask), irq);
      wr(8'h0c, '0);
      rd(8'h0c, st);
      rd(8'h20, '0);
      wr(8'h1c, 32'h1);
      chk("keep", 32'h1, keep);
      i_rst_b <= 1'b0;
      @(posedge i_clock);
      #1 chk("oe", '0, doe);
      chk("keep", '0, keep);
      @(posedge i_clock);
      i_rst_b <= 1'b1;
      dir = '0;
      pol = '0;
      out = '0;
      ien = '0;
      stat = '0;
      mask = '0;
      upd();
      for (int a = 0; a < 32; a += 4) if (a != 12) rd(a[7:0], 32'h0000_0000);
      rd(8'h0c, st);
      chk("irq", '0, irq);
      test_done();
   end
endmodule // digital_io_port_32_line_test
